// *** shared/light_pkg.sv ***
package light_pkg;
  // bus address of the sensor on the serial bus
  localparam logic [6:0] BUS_ADDR = 7'h29;
  // command codes
  localparam logic [7:0] CMD_ACTIVATE = 8'h04;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_STOP = 8'h30;
  localparam int SHUTDOWN_BIT = 7;
  localparam logic [7:0] CMD_ECHO_RESET = 8'h80;
  // result word layout
  localparam int COUNT_W = 15;
  localparam int VALID_BIT = 15;
  localparam int MS_BYTE_HI = 15;
  localparam int MS_BYTE_LO = 8;
  localparam int LS_BYTE_HI = 7;
  localparam int LS_BYTE_LO = 0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 15'h7fff;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 15'h0001;
  // serialiser lengths in bits
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] BITS_ZERO = 5'h00;
  localparam logic [4:0] BITS_ONE = 5'h01;
  // count scale reference: 2.7 lux per count at 50 ms integration
  localparam int REF_INT_MS = 50;
  localparam int REF_MILLILUX_PER_COUNT = 2700;
  // recommended integration granule for 60 Hz flicker, in microseconds
  localparam int FLICKER_60HZ_US = 16660;

  typedef enum logic [1:0] {
    ST_SHUTDOWN,
    ST_ACTIVE,
    ST_INTEGRATE,
    ST_DONE
  } sense_state_e;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } cmd_s;

  typedef struct packed {
    logic start;
    logic word;
    logic shift;
  } rd_req_s;
endpackage

// *** rtl/result_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none
module result_shifter
  import light_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // load and shift control
  input wire logic load,
  input wire logic word,
  input wire logic [15:0] data,
  input wire logic shift,
  // serial data out
  output logic bit_out,
  output logic busy
);
  logic [15:0] sh_ff;
  logic [15:0] nxt_sh;
  logic [4:0] left_ff;
  logic [4:0] nxt_left;
  logic bit_ff;
  logic nxt_bit;

  always_comb begin
    nxt_sh = sh_ff;
    nxt_left = left_ff;
    nxt_bit = bit_ff;
    if (load) begin
      // ms byte goes out first, each byte msb first
      nxt_sh = data; // (RQ12)
      nxt_left = word ? WORD_BITS : BYTE_BITS; // (RQ13)
      nxt_bit = data[MS_BYTE_HI];
    end else if (shift && left_ff != BITS_ZERO) begin
      nxt_sh = {sh_ff[14:0], 1'b1};
      nxt_left = left_ff - BITS_ONE;
      // past the last bit the line is released high
      nxt_bit = (left_ff == BITS_ONE) ? 1'b1 : sh_ff[14]; // (RQ13)
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sh_ff <= RESULT_RESET;
      left_ff <= BITS_ZERO;
      bit_ff <= 1'b1;
    end else begin
      sh_ff <= nxt_sh;
      left_ff <= nxt_left;
      bit_ff <= nxt_bit;
    end
  end

  assign bit_out = bit_ff;
  assign busy = (left_ff != BITS_ZERO);
endmodule
`default_nettype wire

// *** rtl/light_sensor_ctrl.sv ***
// Overview of operation
// (RQ1) host ends integration with a stop command byte to address 0x29
// (RQ2) host reads result as two-byte word, ending with nack and stop
// (RQ3) without stop since start, bit 15 reads zero: count not valid
// (RQ4) after completed conversion bit 15 is one, low 15 bits hold count
// (RQ5) result holds across reads until another full start-to-stop cycle; the code clears it to 0x0000 at the start command
// (RQ6) any command byte with msb set puts the device in shutdown
// (RQ7) host should time integration in multiples of the flicker period
// (RQ8) count scale inverse to integration time; 2.7 lux per count at 50 ms
// (RQ9) command 0x04 leaves shutdown and enters one-shot host-timed mode
// (RQ10) command 0x08 clears result to 0x0000 and starts integration
// (RQ11) command 0x30 halts counting and sets valid bit 15
// (RQ12) result splits into ms byte bits 15..8 and ls byte 7..0
// (RQ13) word read sends ms byte first, each byte msb first
`timescale 1ns/1ps
`default_nettype none
module light_sensor_ctrl
  import light_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // decoded send-byte commands from the bus framer
  input wire cmd_s cmd,
  // one pulse per light-to-frequency conversion tick
  input wire logic light_pulse,
  // read requests from the bus framer
  input wire rd_req_s rd,
  // serial read data and status
  output logic rd_bit,
  output logic rd_busy,
  output logic sensing,
  output logic integrating,
  output logic [15:0] result,
  output logic [7:0] cmd_echo
);
  sense_state_e state_ff;
  sense_state_e nxt_state;
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  logic [15:0] result_ff;
  logic [15:0] nxt_result;
  logic [7:0] echo_ff;
  logic [7:0] nxt_echo;
  logic sensing_ff;
  logic nxt_sensing;
  logic integrating_ff;
  logic nxt_integrating;
  logic cmd_hit;
  logic [COUNT_W-1:0] count_inc;
  logic [15:0] rd_data;

  // one flag per accepted command code
  logic go_shutdown;
  logic go_activate;
  logic go_start;
  logic go_stop;

  // the same codes once the present state allows them
  logic wake_ok;
  logic start_ok;
  logic stop_ok;

  assign cmd_hit = cmd.valid && (cmd.addr == BUS_ADDR);

  // saturate instead of wrapping: a wrapped count would read as dim light
  always_comb begin
    count_inc = count_ff;
    if (light_pulse && count_ff != COUNT_MAX) begin
      count_inc = count_ff + COUNT_ONE; // (RQ8)
    end
  end

  // address first, then the msb, then the code itself
  always_comb begin
    go_shutdown = 1'b0;
    go_activate = 1'b0;
    go_start = 1'b0;
    go_stop = 1'b0;
    if (cmd_hit) begin
      if (cmd.data[SHUTDOWN_BIT]) begin
        go_shutdown = 1'b1; // (RQ6)
      end else begin
        unique case (cmd.data)
          CMD_ACTIVATE: begin
            go_activate = 1'b1; // (RQ9)
          end
          CMD_START: begin
            go_start = 1'b1; // (RQ10)
          end
          CMD_STOP: begin
            go_stop = 1'b1; // (RQ11)
          end
          default: begin
            // reserved and unknown codes change nothing but the echo
          end
        endcase
      end
    end
  end

  assign wake_ok = go_activate && (state_ff == ST_SHUTDOWN); // (RQ9)
  assign start_ok = go_start && (state_ff != ST_SHUTDOWN); // (RQ10)
  // stop only counts after a start; otherwise the result is left alone
  assign stop_ok = go_stop && (state_ff == ST_INTEGRATE); // (RQ11)

  // shutdown wins from any state
  always_comb begin
    nxt_state = state_ff;
    if (go_shutdown) begin
      nxt_state = ST_SHUTDOWN; // (RQ6)
    end else if (wake_ok) begin
      nxt_state = ST_ACTIVE; // (RQ9)
    end else if (start_ok) begin
      nxt_state = ST_INTEGRATE; // (RQ10)
    end else if (stop_ok) begin
      nxt_state = ST_DONE; // (RQ11)
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_SHUTDOWN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // the count keeps running through the stop cycle itself
  always_comb begin
    nxt_count = count_ff;
    if (start_ok) begin
      nxt_count = '0; // (RQ10)
    end else if (state_ff == ST_INTEGRATE) begin
      nxt_count = count_inc; // (RQ8)
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // running count is visible but flagged invalid until stop
  always_comb begin
    nxt_result = result_ff;
    if (start_ok) begin
      nxt_result = RESULT_RESET; // (RQ10)
    end else if (stop_ok) begin
      nxt_result = {1'b1, count_inc}; // (RQ11) (RQ4) (RQ1)
    end else if (state_ff == ST_INTEGRATE) begin
      nxt_result = {1'b0, count_inc}; // (RQ3)
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      result_ff <= RESULT_RESET;
    end else begin
      result_ff <= nxt_result; // (RQ5)
    end
  end

  // any byte at our address is kept, so a shutdown write reads back
  always_comb begin
    nxt_echo = echo_ff;
    if (cmd_hit) begin
      nxt_echo = cmd.data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      echo_ff <= CMD_ECHO_RESET;
    end else begin
      echo_ff <= nxt_echo;
    end
  end

  // sensing and integrating come from flops, so a state decode never glitches them; rd_busy is a decode of the shifter's bit counter
  always_comb begin
    nxt_sensing = (nxt_state != ST_SHUTDOWN);
    nxt_integrating = (nxt_state == ST_INTEGRATE);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sensing_ff <= 1'b0;
      integrating_ff <= 1'b0;
    end else begin
      sensing_ff <= nxt_sensing;
      integrating_ff <= nxt_integrating;
    end
  end

  // a read snapshots the word at its start so a stop mid-read cannot tear it
  always_comb begin
    rd_data = {echo_ff, 8'h00};
    if (rd.word) begin // (RQ2)
      rd_data[MS_BYTE_HI:MS_BYTE_LO] = result_ff[MS_BYTE_HI:MS_BYTE_LO]; // (RQ12)
      rd_data[LS_BYTE_HI:LS_BYTE_LO] = result_ff[LS_BYTE_HI:LS_BYTE_LO]; // (RQ12)
    end
  end

  result_shifter u_shifter (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(rd.start),
    .word(rd.word),
    .data(rd_data),
    .shift(rd.shift),
    .bit_out(rd_bit),
    .busy(rd_busy)
  );

  assign sensing = sensing_ff;
  assign integrating = integrating_ff;
  assign result = result_ff;
  assign cmd_echo = echo_ff;
endmodule
`default_nettype wire

// *** verif/light_chk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module light_chk
  import light_pkg::*;
(
  // watched ports
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire cmd_s cmd,
  input wire logic light_pulse,
  input wire rd_req_s rd,
  input wire logic rd_bit,
  input wire logic rd_busy,
  input wire logic sensing,
  input wire logic integrating,
  input wire logic [15:0] result
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire ok = cmd.valid && cmd.addr == BUS_ADDR;
  property p_act; ok && cmd.data == CMD_ACTIVATE && !sensing |=> sensing; endproperty
  a_act: assert property (p_act) else $error("no wake");
  property p_clr; ok && cmd.data == CMD_START && sensing && !integrating |=> result == RESULT_RESET; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_stop; ok && cmd.data == CMD_STOP && integrating |=> result[15] && !integrating; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_shut; ok && cmd.data[7] |=> !sensing && !integrating; endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_inv; integrating |-> !result[15]; endproperty
  a_inv: assert property (p_inv) else $error("early valid");
  property p_hold; !integrating ##1 !integrating |-> $stable(result); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  // every command cycle at our address left out: a start there clears the count
  property p_cnt; integrating && light_pulse && !ok && result[14:0] != COUNT_MAX
    |=> result[14:0] == $past(result[14:0]) + COUNT_ONE; endproperty
  a_cnt: assert property (p_cnt) else $error("bad count");
  property p_msb; rd.start && rd.word |=> rd_busy && rd_bit == $past(result[15]); endproperty
  a_msb: assert property (p_msb) else $error("bad first bit");
endmodule
bind light_sensor_ctrl light_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .cmd(cmd),
  .light_pulse(light_pulse), .rd(rd), .rd_bit(rd_bit), .rd_busy(rd_busy),
  .sensing(sensing), .integrating(integrating), .result(result));
`default_nettype wire

// *** verif/light_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module light_host
  import light_pkg::*;
(
  // bus side
  input wire logic clk_sys,
  input wire logic rd_bit,
  output cmd_s cmd,
  output rd_req_s rd,
  // collected read
  output logic [15:0] got,
  output logic got_v
);
  initial begin
    cmd = '0;
    rd = '0;
    got_v = 0;
  end
  // released byte is scrambled so a stale value is never trusted
  task send(input logic [6:0] a, input logic [7:0] b);
    @(posedge clk_sys) #1 cmd = {1'b1, a, b};
    @(posedge clk_sys) #1 cmd = {1'b0, ~cmd[14:0]};
  endtask
  task get(input logic w);
    @(posedge clk_sys) #1 rd = {1'b1, w, 1'b0};
    got = '0;
    repeat (w ? 16 : 8) begin
      @(posedge clk_sys) #1 got = {got[14:0], rd_bit};
      rd = 3'b001;
    end
    @(posedge clk_sys) #1 rd = '0;
    got_v = 1;
    @(posedge clk_sys) #1 got_v = 0;
  endtask
endmodule
`default_nettype wire

// *** verif/light_sensor_integration_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module light_sensor_integration_control_tb;
  import light_pkg::*;
  logic clk_sys = 0;
  logic arst_n = 0;
  logic light_pulse = 0;
  logic rd_bit, rd_busy, sensing, integrating, got_v;
  logic [15:0] result, got, word_exp;
  logic [7:0] cmd_echo;
  // last byte the design should have taken at its own address
  logic [7:0] echo = CMD_ECHO_RESET;
  // each note: {sensing, integrating, rd_busy}, echo, result, read word
  logic [42:0] q[$];
  logic [42:0] e;
  logic [31:0] seed = 32'h0001_62be;
  cmd_s cmd;
  rd_req_s rd;
  int n_mismatch = 0;
  int compares = 0;
  int cnt;
  always #25 clk_sys = ~clk_sys;
  light_sensor_ctrl uut (.clk_sys(clk_sys), .arst_n(arst_n), .cmd(cmd), .light_pulse(light_pulse),
    .rd(rd), .rd_bit(rd_bit), .rd_busy(rd_busy), .sensing(sensing), .integrating(integrating),
    .result(result), .cmd_echo(cmd_echo));
  light_host host (.clk_sys(clk_sys), .rd_bit(rd_bit), .cmd(cmd), .rd(rd), .got(got), .got_v(got_v));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task note(input logic [15:0] rd_exp, input logic [15:0] res_exp, input logic [2:0] st_exp);
    q.push_back({st_exp, echo, res_exp, rd_exp});
  endtask
  // commands at our address also move the expected echo
  task send(input logic [6:0] a, input logic [7:0] b);
    host.send(a, b);
    if (a == BUS_ADDR) echo = b;
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // last pulse forced low so the stop cycle adds nothing
  task pulses(input int n);
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      @(posedge clk_sys) #1 light_pulse = seed[0] && i < n - 1;
      cnt += light_pulse;
    end
  endtask
  // outputs are looked at mid-cycle, away from the edge that moves them
  always @(negedge clk_sys) begin
    if (got_v) begin
      if (q.size() == 0) begin
        n_mismatch++;
        $display("MISMATCH note exp queued seen none");
      end else begin
        e = q.pop_front();
        chk("read", got, e[15:0]);
        chk("result", result, e[31:16]);
        chk("echo", {8'h00, cmd_echo}, {8'h00, e[39:32]});
        chk("status", {13'h0000, sensing, integrating, rd_busy}, {13'h0000, e[42:40]});
      end
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 arst_n = 1;
    note({8'h00, echo}, RESULT_RESET, 3'b000);
    host.get(0);
    seed = xs(seed);
    send(BUS_ADDR, 8'h80 | seed[7:0]);
    note({8'h00, echo}, RESULT_RESET, 3'b000);
    host.get(0);
    // a foreign address must be ignored, echo included
    seed = xs(seed);
    send((seed[6:0] == BUS_ADDR) ? ~BUS_ADDR : seed[6:0], CMD_ACTIVATE);
    note({8'h00, echo}, RESULT_RESET, 3'b000);
    host.get(0);
    send(BUS_ADDR, CMD_ACTIVATE);
    note({8'h00, echo}, RESULT_RESET, 3'b100);
    host.get(0);
    repeat (2) begin
      send(BUS_ADDR, CMD_START);
      note(RESULT_RESET, RESULT_RESET, 3'b110);
      host.get(1);
      cnt = 0;
      // integration length stands in for a whole number of flicker periods
      pulses(40);
      send(BUS_ADDR, CMD_STOP);
      word_exp = {1'b1, cnt[14:0]};
      // reserved code only moves the echo
      send(BUS_ADDR, 8'h34);
      note(word_exp, word_exp, 3'b100);
      host.get(1);
      pulses(9);
      // a stop outside integration is refused
      send(BUS_ADDR, CMD_STOP);
      note(word_exp, word_exp, 3'b100);
      host.get(1);
    end
    send(BUS_ADDR, 8'hff);
    note({8'h00, echo}, word_exp, 3'b000);
    host.get(0);
    // second reset mid-run: everything back to power-up values
    @(posedge clk_sys) #1 arst_n = 0;
    repeat (2) @(posedge clk_sys);
    #1 arst_n = 1;
    echo = CMD_ECHO_RESET;
    note({8'h00, echo}, RESULT_RESET, 3'b000);
    host.get(0);
    repeat (3) @(posedge clk_sys);
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    summarize;
  end
endmodule
`default_nettype wire
